/* logic/crf_regs.svh */
// constants of the cpu register set: bit positions, reset values
`ifndef CRF_REGS_SVH
`define CRF_REGS_SVH
`define CRF_CC_C_BIT 0
`define CRF_CC_Z_BIT 1
`define CRF_CC_N_BIT 2
`define CRF_CC_I_BIT 3
`define CRF_CC_H_BIT 4
`define CRF_CC_RESET 8'he8
`define CRF_CC_ONES 8'he0
`define CRF_PC_RESET 16'h0000
`define CRF_DATA_RESET 8'h00
`endif

/* logic/crf_pkg.sv */
// types of the cpu register set
package crf_pkg;
  // register-set operation issued by the instruction decoder
  typedef enum logic [3:0] {
    CRF_OP_NOP, CRF_OP_RESULT, CRF_OP_LD_PC, CRF_OP_PC_INC,
    CRF_OP_SET_CARRY, CRF_OP_CLR_CARRY, CRF_OP_SET_MASK, CRF_OP_CLR_MASK,
    CRF_OP_POP_FLAGS, CRF_OP_INT_ENTRY, CRF_OP_RET_FLAGS
  } crf_op_t;
  // destination of a result
  typedef enum logic [1:0] {CRF_DST_NONE, CRF_DST_A, CRF_DST_X, CRF_DST_Y} crf_dst_t;
  // branch condition under test
  typedef enum logic [3:0] {
    CRF_BR_HC, CRF_BR_NHC, CRF_BR_M, CRF_BR_NM, CRF_BR_MI, CRF_BR_PL,
    CRF_BR_EQ, CRF_BR_NE, CRF_BR_C, CRF_BR_NC
  } crf_cond_t;
  // one command per cycle from the decoder and alu
  typedef struct packed {
    crf_op_t op;
    crf_dst_t dst;
    logic [7:0] res;
    logic nz_en;
    logic c_en;
    logic cout;
    logic h_en;
    logic hcarry;
    logic is_trap;
    logic [15:0] pc_data;
  } crf_cmd_t;
  // programmer view of the registers
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] idx_x;
    logic [7:0] idx_y;
    logic [15:0] pc;
    logic [7:0] cc;
  } crf_view_t;
  // whole state of the block
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] idx_x;
    logic [7:0] idx_y;
    logic [15:0] pc;
    logic h;
    logic i;
    logic n;
    logic z;
    logic c;
    logic pend;
  } crf_state_t;
endpackage

/* logic/crf_core.sv */
// cpu register set with condition code flags and pending interrupt latch
// Notes on behaviour
// RQ1 - eight-bit accumulator holds operands and results
// RQ2 - two eight-bit index registers
// RQ3 - interrupt stacking never touches second index
// RQ4 - sixteen-bit instruction pointer, low and high bytes
// RQ5 - flags reset to 111x1xxx, mask set
// RQ6 - flags pushable, poppable, each bit testable
// RQ7 - add sets half carry from bit three
// RQ8 - half-carry branches read half-carry flag
// RQ9 - mask set on entry, blocks all but trap
// RQ10 - mask cleared, set, restored and tested
// RQ11 - requests while masked stay pending
// RQ12 - clearing mask takes pending requests immediately
// RQ13 - negative flag copies result bit seven
// RQ14 - minus and plus branches read negative
// RQ15 - zero flag follows zero result
// RQ16 - equal branches read zero flag
// RQ17 - carry follows overflow, writable by software
// RQ18 - carry forced, tested, updated by shifts
// RQ19 - registers have no memory address
// RQ20 - flag bits seven, six, five read one
`include "crf_regs.svh"
module crf_core (
  input wire logic clk,
  input wire logic rst,
  input crf_pkg::crf_cmd_t cmd,
  input crf_pkg::crf_cond_t br_cond,
  input wire logic irq_req,
  output crf_pkg::crf_view_t view,
  output logic [7:0] pc_low,
  output logic [7:0] pc_high,
  output logic br_taken,
  output logic irq_take
);
  import crf_pkg::*;

  // registered and next state
  crf_state_t st_r;
  crf_state_t st_nxt;
  // flag byte as read and as written
  logic [7:0] cc_rd;
  logic [7:0] cc_wr;

  // flag byte assembly, fixed ones in the top bits
  // RQ20 fixed one bits
  always_comb begin
    cc_rd = `CRF_CC_ONES;
    cc_rd[`CRF_CC_H_BIT] = st_r.h;
    cc_rd[`CRF_CC_I_BIT] = st_r.i;
    cc_rd[`CRF_CC_N_BIT] = st_r.n;
    cc_rd[`CRF_CC_Z_BIT] = st_r.z;
    cc_rd[`CRF_CC_C_BIT] = st_r.c;
  end

  // popped byte; top bits are ignored
  assign cc_wr = cmd.res;

  // next state from the decoder command
  always_comb begin
    st_nxt = st_r;
    // RQ11 latch requests while masked
    if (irq_req) begin
      st_nxt.pend = 1'b1;
    end
    unique case (cmd.op)
      // idle cycle, state held
      CRF_OP_NOP: begin
      end
      // alu or load result
      CRF_OP_RESULT: begin
        // RQ1 accumulator write
        if (cmd.dst == CRF_DST_A) begin
          st_nxt.acc = cmd.res;
        end
        // RQ2 index register write
        if (cmd.dst == CRF_DST_X) begin
          st_nxt.idx_x = cmd.res;
        end
        if (cmd.dst == CRF_DST_Y) begin
          st_nxt.idx_y = cmd.res;
        end
        // RQ13 negative from bit seven
        if (cmd.nz_en) begin
          st_nxt.n = cmd.res[7];
          // RQ15 zero on null result
          st_nxt.z = (cmd.res == 8'h00);
        end
        // RQ17 carry from alu
        if (cmd.c_en) begin
          st_nxt.c = cmd.cout;
        end
        // RQ7 half carry on add
        if (cmd.h_en) begin
          st_nxt.h = cmd.hcarry;
        end
      end
      // RQ4 pointer load
      CRF_OP_LD_PC: begin
        st_nxt.pc = cmd.pc_data;
      end
      // RQ4 pointer step, wraps
      CRF_OP_PC_INC: begin
        st_nxt.pc = st_r.pc + 16'h0001;
      end
      // RQ18 carry forced by software
      CRF_OP_SET_CARRY: begin
        st_nxt.c = 1'b1;
      end
      // RQ18 carry cleared by software
      CRF_OP_CLR_CARRY: begin
        st_nxt.c = 1'b0;
      end
      // RQ10 mask set by software
      CRF_OP_SET_MASK: begin
        st_nxt.i = 1'b1;
      end
      // RQ10 mask cleared by software
      CRF_OP_CLR_MASK: begin
        st_nxt.i = 1'b0;
      end
      // RQ6 flags from stack
      CRF_OP_POP_FLAGS, CRF_OP_RET_FLAGS: begin
        st_nxt.h = cc_wr[`CRF_CC_H_BIT];
        st_nxt.i = cc_wr[`CRF_CC_I_BIT];
        st_nxt.n = cc_wr[`CRF_CC_N_BIT];
        st_nxt.z = cc_wr[`CRF_CC_Z_BIT];
        st_nxt.c = cc_wr[`CRF_CC_C_BIT];
      end
      // RQ9 mask set on entry
      CRF_OP_INT_ENTRY: begin
        st_nxt.i = 1'b1;
        st_nxt.pc = cmd.pc_data;
        // RQ3 second index left alone
        st_nxt.idx_y = st_r.idx_y;
        // a new request in this cycle wins over the clear
        if (!cmd.is_trap && !irq_req) begin
          st_nxt.pend = 1'b0;
        end
      end
      // unused op codes leave state
      default: begin
      end
    endcase
  end

  // state register
  // RQ5 reset pattern
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r.acc <= `CRF_DATA_RESET;
      st_r.idx_x <= `CRF_DATA_RESET;
      st_r.idx_y <= `CRF_DATA_RESET;
      st_r.pc <= `CRF_PC_RESET;
      st_r.h <= 1'b0;
      st_r.i <= 1'b1;
      st_r.n <= 1'b0;
      st_r.z <= 1'b0;
      st_r.c <= 1'b0;
      st_r.pend <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // register view; no address decode anywhere
  // RQ19 instruction-only access
  assign view.acc = st_r.acc;
  assign view.idx_x = st_r.idx_x;
  assign view.idx_y = st_r.idx_y;
  assign view.pc = st_r.pc;
  assign view.cc = cc_rd;
  // RQ4 pointer bytes
  assign pc_low = st_r.pc[7:0];
  assign pc_high = st_r.pc[15:8];

  // RQ12 pending taken once unmasked
  assign irq_take = st_r.pend && !st_r.i;

  // branch condition evaluation
  always_comb begin
    unique case (br_cond)
      // RQ8 half carry tests
      CRF_BR_HC: br_taken = st_r.h;
      CRF_BR_NHC: br_taken = !st_r.h;
      // RQ10 mask tests
      CRF_BR_M: br_taken = st_r.i;
      CRF_BR_NM: br_taken = !st_r.i;
      // RQ14 sign tests
      CRF_BR_MI: br_taken = st_r.n;
      CRF_BR_PL: br_taken = !st_r.n;
      // RQ16 zero tests
      CRF_BR_EQ: br_taken = st_r.z;
      CRF_BR_NE: br_taken = !st_r.z;
      // RQ18 carry tests
      CRF_BR_C: br_taken = st_r.c;
      CRF_BR_NC: br_taken = !st_r.c;
      default: br_taken = 1'b0;
    endcase
  end

  // checks on the register set
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // RQ20 top bits fixed
  AST_TOP_ONES: assert property (view.cc[7:5] == 3'b111) // RQ20
    else $error("flag top bits not one");
  // RQ9 mask on entry
  AST_ENTRY_MASK: assert property (cmd.op == CRF_OP_INT_ENTRY |=> view.cc[3]) // RQ9
    else $error("mask not set on entry");
  // RQ3 kept on entry
  AST_ENTRY_Y: assert property (cmd.op == CRF_OP_INT_ENTRY // RQ3
    |=> view.idx_y == $past(view.idx_y))
    else $error("second index changed by entry");
  // RQ3 kept on return
  AST_RET_Y: assert property (cmd.op == CRF_OP_RET_FLAGS // RQ3
    |=> view.idx_y == $past(view.idx_y))
    else $error("second index changed by return");
  // RQ10 software clears mask
  AST_UNMASK: assert property (cmd.op == CRF_OP_CLR_MASK |=> !view.cc[3]) // RQ10
    else $error("mask not cleared");
  // RQ10 software sets mask
  AST_MASK_SET: assert property (cmd.op == CRF_OP_SET_MASK |=> view.cc[3]) // RQ10
    else $error("mask not set");
  // RQ11 masked request held
  AST_HOLD_PEND: assert property (irq_req && view.cc[3] // RQ11
    && cmd.op != CRF_OP_CLR_MASK |=> st_r.pend)
    else $error("masked request lost");
  // RQ11 pending stays masked
  AST_PEND_KEEP: assert property (st_r.pend && view.cc[3] // RQ11
    && cmd.op != CRF_OP_INT_ENTRY |=> st_r.pend)
    else $error("pending request dropped");
  // RQ12 taken once unmasked
  AST_TAKE: assert property (st_r.pend && cmd.op == CRF_OP_CLR_MASK && !irq_req // RQ12
    |=> irq_take)
    else $error("pending not taken after unmask");
  // RQ9 trap keeps pending
  AST_TRAP_PEND: assert property (cmd.op == CRF_OP_INT_ENTRY && cmd.is_trap // RQ9
    && st_r.pend |=> st_r.pend)
    else $error("trap dropped a pending request");
  // RQ11 entry services pending
  AST_ENTRY_CLR: assert property (cmd.op == CRF_OP_INT_ENTRY && !cmd.is_trap // RQ11
    && !irq_req |=> !st_r.pend)
    else $error("serviced request still pending");
  // RQ13 sign copy
  AST_NZ: assert property (cmd.op == CRF_OP_RESULT && cmd.nz_en // RQ13
    |=> view.cc[2] == $past(cmd.res[7]))
    else $error("sign flag wrong");
  // RQ15 zero detect
  AST_ZERO: assert property (cmd.op == CRF_OP_RESULT && cmd.nz_en // RQ15
    |=> view.cc[1] == ($past(cmd.res) == 8'h00))
    else $error("zero flag wrong");
  // RQ7 half carry
  AST_HALF: assert property (cmd.op == CRF_OP_RESULT && cmd.h_en // RQ7
    |=> view.cc[4] == $past(cmd.hcarry))
    else $error("half carry wrong");
  // RQ17 carry from alu
  AST_CARRY: assert property (cmd.op == CRF_OP_RESULT && cmd.c_en // RQ17
    |=> view.cc[0] == $past(cmd.cout))
    else $error("carry flag wrong");
  // RQ18 carry forced
  AST_CARRY_SET: assert property (cmd.op == CRF_OP_SET_CARRY |=> view.cc[0]) // RQ18
    else $error("carry not forced");
  // RQ18 carry cleared
  AST_CARRY_CLR: assert property (cmd.op == CRF_OP_CLR_CARRY |=> !view.cc[0]) // RQ18
    else $error("carry not cleared");
  // RQ6 flags from stack
  AST_POP: assert property (cmd.op == CRF_OP_POP_FLAGS // RQ6
    |=> view.cc[4:0] == $past(cmd.res[4:0]))
    else $error("popped flags wrong");

  // data and pointer registers
  // RQ1 accumulator write
  AST_ACC: assert property (cmd.op == CRF_OP_RESULT && cmd.dst == CRF_DST_A // RQ1
    |=> view.acc == $past(cmd.res))
    else $error("accumulator not written");
  // RQ2 first index write
  AST_IDX_X: assert property (cmd.op == CRF_OP_RESULT && cmd.dst == CRF_DST_X // RQ2
    |=> view.idx_x == $past(cmd.res))
    else $error("first index not written");
  // RQ4 pointer load bytes
  AST_PCB: assert property (cmd.op == CRF_OP_LD_PC // RQ4
    |=> {pc_high, pc_low} == $past(cmd.pc_data))
    else $error("pointer bytes mismatch");
  // RQ4 pointer step
  AST_PC_STEP: assert property (cmd.op == CRF_OP_PC_INC // RQ4
    |=> view.pc == $past(view.pc) + 16'h0001)
    else $error("pointer not stepped");

  // branch decode against the flag byte
  // RQ8 half carry branch
  AST_BR_HALF: assert property (br_cond == CRF_BR_HC |-> br_taken == view.cc[4]) // RQ8
    else $error("half carry branch wrong");
  // RQ10 mask branch
  AST_BR_MASK: assert property (br_cond == CRF_BR_NM |-> br_taken == !view.cc[3]) // RQ10
    else $error("mask branch wrong");
  // RQ14 sign branch
  AST_BR_SIGN: assert property (br_cond == CRF_BR_MI |-> br_taken == view.cc[2]) // RQ14
    else $error("sign branch wrong");
  // RQ16 zero branch
  AST_BR_ZERO: assert property (br_cond == CRF_BR_NE |-> br_taken == !view.cc[1]) // RQ16
    else $error("zero branch wrong");
  // RQ18 carry branch
  AST_BR_CARRY: assert property (br_cond == CRF_BR_C |-> br_taken == view.cc[0]) // RQ18
    else $error("carry branch wrong");
endmodule

/* tb/crf_test.sv */
// self-checking bench of the cpu register set and flags
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module cpu_register_set_and_flags_test import crf_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, irq_req, br_taken, irq_take;
  logic [7:0] pc_low, pc_high;
  crf_cmd_t cmd; // decoder command
  crf_cond_t br_cond; // branch selector
  crf_view_t view; // programmer view
  int mismatches = 0;
  int num_checks = 0;
  crf_core u_dut (.clk(clk), .rst(rst), .cmd(cmd), .br_cond(br_cond), .irq_req(irq_req),
    .view(view), .pc_low(pc_low), .pc_high(pc_high), .br_taken(br_taken), .irq_take(irq_take));
  // 20 mhz clock
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  // one command for one edge, then nop; fl is {nz_en, c_en, cout, h_en, hcarry}
  task run(input crf_op_t op, input crf_dst_t dst, input logic [7:0] res,
      input logic [15:0] pd, input logic [4:0] fl);
    crf_cmd_t c;
    c = '0;
    c.op = op;
    c.dst = dst;
    c.res = res;
    c.pc_data = pd;
    {c.nz_en, c.c_en, c.cout, c.h_en, c.hcarry} = fl;
    @(negedge clk);
    cmd = c;
    @(negedge clk);
    cmd = '0;
  endtask
  // branch decision for one condition, selector changed at the falling edge
  task br(input crf_cond_t c, input logic e);
    @(negedge clk);
    br_cond = c;
    #1 `CHK(br_taken, e)
  endtask
  // one interrupt entry with trap flag and request level beside it
  task entry(input logic trap, input logic req, input logic [15:0] vec);
    crf_cmd_t c;
    c = '0;
    c.op = CRF_OP_INT_ENTRY;
    c.is_trap = trap;
    c.pc_data = vec;
    @(negedge clk);
    cmd = c;
    irq_req = req;
    @(negedge clk);
    cmd = '0;
    irq_req = 1'h0;
  endtask
  task t_reset;
    `CHK(view.cc, 8'he8)
    `CHK(view.acc, 8'h00)
    `CHK(view.idx_x, 8'h00)
    `CHK(view.idx_y, 8'h00)
    `CHK(view.pc, 16'h0000)
    `CHK(irq_take, 1'b0)
    $display("test reset done");
  endtask
  task t_nz;
    run(CRF_OP_RESULT, CRF_DST_A, 8'h80, 16'h0000, 5'h10);
    `CHK(view.acc, 8'h80)
    `CHK(view.cc[2], 1'b1)
    `CHK(view.cc[1], 1'b0)
    br(CRF_BR_MI, 1'b1);
    br(CRF_BR_PL, 1'b0);
    run(CRF_OP_RESULT, CRF_DST_X, 8'h5a, 16'h0000, 5'h10);
    `CHK(view.idx_x, 8'h5a)
    br(CRF_BR_NE, 1'b1);
    run(CRF_OP_RESULT, CRF_DST_A, 8'h00, 16'h0000, 5'h10);
    `CHK(view.cc[2:1], 2'b01)
    br(CRF_BR_EQ, 1'b1);
    $display("test negative zero done");
  endtask
  task t_cy;
    run(CRF_OP_RESULT, CRF_DST_NONE, 8'h01, 16'h0000, 5'h0f);
    `CHK(view.cc[4], 1'b1)
    `CHK(view.cc[0], 1'b1)
    br(CRF_BR_HC, 1'b1);
    br(CRF_BR_C, 1'b1);
    run(CRF_OP_RESULT, CRF_DST_NONE, 8'h01, 16'h0000, 5'h0a);
    `CHK(view.cc[4], 1'b0)
    `CHK(view.cc[0], 1'b0)
    br(CRF_BR_NHC, 1'b1);
    run(CRF_OP_SET_CARRY, CRF_DST_NONE, 8'h00, 16'h0000, 5'h00);
    `CHK(view.cc[0], 1'b1)
    run(CRF_OP_CLR_CARRY, CRF_DST_NONE, 8'h00, 16'h0000, 5'h00);
    br(CRF_BR_NC, 1'b1);
    $display("test carry done");
  endtask
  task t_irq;
    run(CRF_OP_RESULT, CRF_DST_Y, 8'hc3, 16'h0000, 5'h10);
    run(CRF_OP_CLR_MASK, CRF_DST_NONE, 8'h00, 16'h0000, 5'h00);
    br(CRF_BR_NM, 1'b1);
    br(CRF_BR_M, 1'b0);
    run(CRF_OP_SET_MASK, CRF_DST_NONE, 8'h00, 16'h0000, 5'h00);
    br(CRF_BR_M, 1'b1);
    // request while masked stays pending
    @(negedge clk) irq_req = 1;
    @(negedge clk) irq_req = 0;
    `CHK(irq_take, 1'b0)
    run(CRF_OP_CLR_MASK, CRF_DST_NONE, 8'h00, 16'h0000, 5'h00);
    `CHK(irq_take, 1'b1)
    br(CRF_BR_NM, 1'b1);
    run(CRF_OP_INT_ENTRY, CRF_DST_NONE, 8'h00, 16'hf1e2, 5'h00);
    `CHK(view.cc[3], 1'b1)
    `CHK(irq_take, 1'b0)
    `CHK(view.idx_y, 8'hc3)
    `CHK({pc_high, pc_low}, 16'hf1e2)
    run(CRF_OP_RET_FLAGS, CRF_DST_NONE, 8'h00, 16'h0000, 5'h00);
    `CHK(view.cc, 8'he0)
    `CHK(view.idx_y, 8'hc3)
    $display("test interrupt done");
  endtask
  task t_pop_pc;
    run(CRF_OP_POP_FLAGS, CRF_DST_NONE, 8'h1f, 16'h0000, 5'h00);
    `CHK(view.cc, 8'hff)
    run(CRF_OP_LD_PC, CRF_DST_NONE, 8'h00, 16'hffff, 5'h00);
    `CHK(view.pc, 16'hffff)
    run(CRF_OP_PC_INC, CRF_DST_NONE, 8'h00, 16'h0000, 5'h00);
    `CHK(view.pc, 16'h0000)
    $display("test pop and pointer done");
  endtask
  // trap keeps a pending request, a request beside entry outlives its clear
  task t_trap;
    run(CRF_OP_SET_MASK, CRF_DST_NONE, 8'h00, 16'h0000, 5'h00);
    @(negedge clk) irq_req = 1'h1;
    @(negedge clk) irq_req = 1'h0;
    entry(1'h1, 1'h0, 16'h1234);
    `CHK(view.pc, 16'h1234)
    `CHK(irq_take, 1'h0)
    run(CRF_OP_CLR_MASK, CRF_DST_NONE, 8'h00, 16'h0000, 5'h00);
    `CHK(irq_take, 1'h1)
    entry(1'h0, 1'h1, 16'h2345);
    `CHK(view.cc[3], 1'h1)
    run(CRF_OP_CLR_MASK, CRF_DST_NONE, 8'h00, 16'h0000, 5'h00);
    `CHK(irq_take, 1'h1)
    entry(1'h0, 1'h0, 16'h3456);
    run(CRF_OP_CLR_MASK, CRF_DST_NONE, 8'h00, 16'h0000, 5'h00);
    `CHK(irq_take, 1'h0)
    $display("test trap done");
  endtask
  // reset in mid-run brings every register and the pending latch back
  task t_rst2;
    run(CRF_OP_RESULT, CRF_DST_A, 8'h77, 16'h0000, 5'h00);
    run(CRF_OP_RESULT, CRF_DST_Y, 8'h99, 16'h0000, 5'h00);
    run(CRF_OP_LD_PC, CRF_DST_NONE, 8'h00, 16'habcd, 5'h00);
    @(negedge clk) irq_req = 1'h1;
    @(negedge clk) irq_req = 1'h0;
    @(negedge clk) rst = 1'h1;
    repeat (2) @(negedge clk);
    rst = 1'h0;
    `CHK(view.acc, 8'h00)
    `CHK(view.idx_x, 8'h00)
    `CHK(view.idx_y, 8'h00)
    `CHK(view.pc, 16'h0000)
    `CHK(view.cc, 8'he8)
    `CHK(irq_take, 1'h0)
    run(CRF_OP_CLR_MASK, CRF_DST_NONE, 8'h00, 16'h0000, 5'h00);
    `CHK(irq_take, 1'h0)
    `CHK(view.cc, 8'he0)
    $display("test second reset done");
  endtask
  // counts and verdict, then stop
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // watchdog well past the roughly eighty cycles of the run
  initial begin
    #50000;
    mismatches++;
    test_done;
  end
  // main sequence
  initial begin
    rst = 1;
    cmd = '0;
    br_cond = CRF_BR_HC;
    irq_req = 0;
    repeat (5) @(posedge clk);
    @(negedge clk) rst = 0;
    t_reset;
    t_nz;
    t_cy;
    t_irq;
    t_trap;
    t_pop_pc;
    t_rst2;
    test_done;
  end
endmodule
